// >>> bench/blrfd_core_model.sv
/*
 * Behavioural model of the processor core as seen by the decoder: it
 * issues single self-write or table-read access pulses and holds the
 * place of execution and of the interrupt vectors as levels.
 * Assumes the bench calls its tasks hierarchically, one at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module blrfd_core_model (
    // Clock
    input  wire logic clk,
    // Access request towards the decoder
    output var  logic acc_valid,
    output var  logic acc_write,
    output var  logic acc_boot,
    output var  logic exec_in_boot,
    output var  logic ivec_in_boot,
    // Decision from the decoder
    input  wire logic acc_grant,
    input  wire logic acc_deny
);
    // Idle levels at time zero
    initial begin
        acc_valid    = 1'b0;
        acc_write    = 1'b0;
        acc_boot     = 1'b0;
        exec_in_boot = 1'b0;
        ivec_in_boot = 1'b0;
    end

    // Execution place and vector place change only between accesses
    task automatic set_ctx(input logic ex_boot, input logic iv_boot);
        @(posedge clk);
        exec_in_boot <= ex_boot;
        ivec_in_boot <= iv_boot;
    endtask : set_ctx

    // One access pulse; qualifiers flip afterwards so stale values
    // can never pass for a held request
    task automatic access(input logic wr, input logic boot,
                          output logic [1:0] gd);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_boot  <= boot;
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_write <= ~wr;
        acc_boot  <= ~boot;
        @(posedge clk);
        gd = {acc_grant, acc_deny};
    endtask : access
endmodule : blrfd_core_model

`default_nettype wire

// >>> bench/tb_top.sv
/*
 * Self-checking bench of the boot lock and reset fuse decoder: walks
 * all sixteen section lock settings and all output forcing settings,
 * then the lock image register.
 * Assumes blrfd_pkg and the core model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

`include "blrfd_defines.svh"

module tb_top;
    import blrfd_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  ext_fuse_in = 8'hff;
    logic [7:0]  lock_byte_in = 8'hff;
    logic        lock_nv_wr;
    logic [7:0]  lock_nv_data;
    logic        acc_valid, acc_write, acc_boot, exec_in_boot;
    logic        ivec_in_boot, acc_grant, acc_deny, irq_suppress;
    logic [2:0]  stage_a_in = 3'h5;
    logic [2:0]  stage_b_in = 3'h2;
    logic [2:0]  stage_output_a, stage_output_b;
    logic        stage_force;
    integer      error_cnt = 0;
    integer      n_checks = 0;
    integer      nv_pulses = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Count store pulses towards the nonvolatile array
    always @(posedge clk) if (lock_nv_wr === 1'b1) nv_pulses++;

    blrfd_top i_blrfd_top (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_fuse_in(ext_fuse_in), .lock_byte_in(lock_byte_in),
        .lock_nv_wr(lock_nv_wr), .lock_nv_data(lock_nv_data),
        .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_boot(acc_boot), .exec_in_boot(exec_in_boot),
        .ivec_in_boot(ivec_in_boot), .acc_grant(acc_grant),
        .acc_deny(acc_deny), .irq_suppress(irq_suppress),
        .stage_a_in(stage_a_in), .stage_b_in(stage_b_in),
        .stage_output_a(stage_output_a), .stage_output_b(stage_output_b),
        .stage_force(stage_force));

    blrfd_core_model i_blrfd_core_model (
        .clk(clk), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_boot(acc_boot), .exec_in_boot(exec_in_boot),
        .ivec_in_boot(ivec_in_boot), .acc_grant(acc_grant),
        .acc_deny(acc_deny));

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [4:0] a,
                            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50) begin
            error_cnt++;
            final_report();
        end
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_writedata <= ~wd;
    endtask : bus_xfer

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(1'b1, a, d, dummy);
    endtask : wr_reg

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus_xfer(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask : rd_chk

    // Reset with given nonvolatile bytes; the pins are checked in reset
    task automatic do_reset(input logic [7:0] lk, input logic [7:0] ex);
        logic [2:0] ea;
        logic [2:0] eb;
        ea = ex[5] ? 3'h0 : {3{~ex[4]}};
        eb = ex[5] ? 3'h0 : {3{~ex[3]}};
        rst_n        <= 1'b0;
        lock_byte_in <= lk;
        ext_fuse_in  <= ex;
        repeat (15) @(posedge clk);
        #1;
        check({stage_force, stage_output_a, stage_output_b},
              {~ex[5], ea, eb});
        @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset

    // Main sequence
    initial begin
        logic [7:0] lk;
        logic [7:0] ex;
        logic [1:0] gd;
        logic       fc;
        int         base;
        for (int i = 0; i < 16; i++) begin
            lk = {2'b11, i[3:0], 2'b11};
            ex = {2'b11, i[2:0], 3'b101};
            fc = ~ex[5];
            do_reset(lk, ex);
            // Inputs move after reset; decoder must stay frozen
            lock_byte_in <= ~lk;
            ext_fuse_in  <= ~ex;
            rd_chk(`BLRFD_OFF_EXT, {24'h0, ex});
            rd_chk(`BLRFD_OFF_LOCK, {24'h0, lk});
            check({stage_output_a, stage_output_b},
                  fc ? {{3{~ex[4]}}, {3{~ex[3]}}} : 6'h2a);
            i_blrfd_core_model.set_ctx(1'b1, 1'b0);
            i_blrfd_core_model.access(1'b1, 1'b0, gd);
            check(gd, {i[0], ~i[0]});
            i_blrfd_core_model.access(1'b0, 1'b0, gd);
            check(gd, {i[1], ~i[1]});
            check(irq_suppress, !i[3]);
            i_blrfd_core_model.set_ctx(1'b0, 1'b1);
            i_blrfd_core_model.access(1'b1, 1'b1, gd);
            check(gd, {i[2], ~i[2]});
            i_blrfd_core_model.access(1'b0, 1'b1, gd);
            check(gd, {i[3], ~i[3]});
            check(irq_suppress, !i[1]);
            i_blrfd_core_model.access(1'b0, 1'b0, gd);
            check(gd, 2'b10);
            i_blrfd_core_model.set_ctx(1'b1, 1'b1);
            repeat (2) @(posedge clk);
            check(irq_suppress, 1'b0);
            rd_chk(`BLRFD_OFF_STAT, {30'h0, ~&i[3:0], fc});
            wr_reg(`BLRFD_OFF_STAT, 32'h2);
            rd_chk(`BLRFD_OFF_STAT, {30'h0, 1'b0, fc});
            // Even settings write with lane 0 off: release, no store
            avs_byteenable <= {3'h0, i[0]};
            wr_reg(`BLRFD_OFF_OCFG, 32'hffff_ffff);
            avs_byteenable <= 4'h1;
            #1;
            check({stage_force, stage_output_a, stage_output_b},
                  7'h2a);
            rd_chk(`BLRFD_OFF_OCFG, i[0] ? 32'h3f : 32'h0);
            $display("test lock and fuse setting %0d done", i);
        end
        // Lock image: protection bits before main locks, erase only
        do_reset(8'hff, 8'hff);
        base = nv_pulses;
        rd_chk(`BLRFD_OFF_LPROG, 32'hff);
        wr_reg(`BLRFD_OFF_LPROG, 32'h0c3);
        rd_chk(`BLRFD_OFF_LPROG, 32'hc3);
        wr_reg(`BLRFD_OFF_LPROG, 32'h0fc);
        rd_chk(`BLRFD_OFF_LPROG, 32'hc0);
        wr_reg(`BLRFD_OFF_LPROG, 32'h0ff);
        rd_chk(`BLRFD_OFF_LPROG, 32'hc0);
        check(lock_nv_data, 8'hc0);
        wr_reg(`BLRFD_OFF_LPROG, 32'h1ff);
        rd_chk(`BLRFD_OFF_LPROG, 32'hff);
        rd_chk(5'h14, 32'h0);
        check(nv_pulses - base, 4);
        $display("test lock image done");
        final_report();
    end
endmodule : tb_top

`default_nettype wire

// >>> pkg/blrfd_defines.svh
/*
 * Constants of the boot lock and reset fuse decoder: register byte
 * offsets, fuse and lock bit positions, reset values.
 * Assumes it is included by bare name, by package and design alike.
 */
`ifndef BLRFD_DEFINES_SVH
`define BLRFD_DEFINES_SVH

// Register byte offsets, one aligned word each
`define BLRFD_ADDR_W     5
`define BLRFD_OFF_EXT    5'h00
`define BLRFD_OFF_LOCK   5'h04
`define BLRFD_OFF_OCFG   5'h08
`define BLRFD_OFF_STAT   5'h0c
`define BLRFD_OFF_LPROG  5'h10

// Extended configuration byte fields
`define BLRFD_EXT_RB     3'h5
`define BLRFD_EXT_RVA    3'h4
`define BLRFD_EXT_RVB    3'h3

// Lock byte fields
`define BLRFD_BOOT_HI    3'h5
`define BLRFD_BOOT_LO    3'h4
`define BLRFD_APP_HI     3'h3
`define BLRFD_APP_LO     3'h2

// Widths, values and misc
`define BLRFD_OCFG_W     6
`define BLRFD_UNPROG     8'hff
`define BLRFD_ERASE_BIT  8
`define BLRFD_STAT_FORCE 0
`define BLRFD_STAT_DENY  1
`define BLRFD_RST_EDGES  3

`endif

// >>> pkg/blrfd_pkg.sv
/*
 * Types of the boot lock and reset fuse decoder: bus phase and the
 * single packed state record of the top module.
 * Assumes blrfd_defines.svh is on the include path.
 */
package blrfd_pkg;
    `include "blrfd_defines.svh"

    // Register bus phase
    typedef enum logic {
        BLRFD_BUS_IDLE,
        BLRFD_BUS_ACK
    } blrfd_bus_t;

    // All state of the top module
    typedef struct packed {
        logic [7:0]               ext_s1_q;
        logic [7:0]               ext_s2_q;
        logic [7:0]               lock_s1_q;
        logic [7:0]               lock_s2_q;
        logic [7:0]               ext_q;
        logic [7:0]               lock_q;
        logic                     force_q;
        logic [2:0]               out_a_q;
        logic [2:0]               out_b_q;
        logic [`BLRFD_OCFG_W-1:0] ocfg_q;
        blrfd_bus_t               bus_q;
        logic                     wait_q;
        logic [31:0]              rdata_q;
        logic                     grant_q;
        logic                     deny_q;
        logic                     irq_sup_q;
        logic                     deny_stk_q;
        logic                     nv_wr_q;
        logic [7:0]               nv_data_q;
    } blrfd_state_t;
endpackage : blrfd_pkg

// >>> src/blrfd_sect.sv
/*
 * Protection decode for one program memory section from its pair of
 * lock bits. Purely combinational; the caller registers the results.
 * Assumes the access qualifiers are already steered to this section.
 */
`timescale 1ns/1ps
`default_nettype none

module blrfd_sect (
    // Lock pair of this section, 0 means programmed
    input  wire logic prot_hi,
    input  wire logic prot_lo,
    // Access aimed at this section
    input  wire logic acc_wr,
    input  wire logic acc_rd,
    // Where the core executes and where its vectors sit
    input  wire logic from_other,
    input  wire logic exec_here,
    input  wire logic ivec_other,
    // Decisions
    output var  logic wr_blk,
    output var  logic rd_blk,
    output var  logic irq_blk
);
    logic prog_hi;
    logic prog_lo;

    // A programmed bit reads as zero
    assign prog_hi = ~prot_hi;
    assign prog_lo = ~prot_lo;

    // Low bit programmed stops self-writes in modes 2 and 3
    assign wr_blk = acc_wr & prog_lo;

    // High bit programmed stops reads issued from the other section
    assign rd_blk = acc_rd & from_other & prog_hi;

    // Vectors elsewhere cannot be trusted to reach locked code
    assign irq_blk = prog_hi & exec_here & ivec_other;
endmodule : blrfd_sect

`default_nettype wire

// >>> src/blrfd_top.sv
/*
 * Boot lock and reset fuse decoder. Samples the lock byte and the
 * extended configuration byte during reset, judges each self-write or
 * table-read access of the core, masks interrupts, and forces the
 * power stage outputs until the output configuration register is
 * written. Registers are reached over an Avalon-MM slave.
 * Assumes the nonvolatile array drives both bytes steadily and that
 * rst_n is held low for at least three clock edges.
 */
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "blrfd_defines.svh"

module blrfd_top (
    // Clock and synchronous reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Avalon-MM slave
    input  wire logic [`BLRFD_ADDR_W-1:0] avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output var  logic [31:0]              avs_readdata,
    output var  logic                     avs_waitrequest,
    // Nonvolatile bytes, outside this clock domain
    input  wire logic [7:0]               ext_fuse_in,
    input  wire logic [7:0]               lock_byte_in,
    // Lock image back to the nonvolatile array
    output var  logic                     lock_nv_wr,
    output var  logic [7:0]               lock_nv_data,
    // Core program memory access check
    input  wire logic                     acc_valid,
    input  wire logic                     acc_write,
    input  wire logic                     acc_boot,
    input  wire logic                     exec_in_boot,
    input  wire logic                     ivec_in_boot,
    output var  logic                     acc_grant,
    output var  logic                     acc_deny,
    output var  logic                     irq_suppress,
    // Power stage outputs
    input  wire logic [2:0]               stage_a_in,
    input  wire logic [2:0]               stage_b_in,
    output var  logic [2:0]               stage_output_a,
    output var  logic [2:0]               stage_output_b,
    output var  logic                     stage_force
);
    import blrfd_pkg::*;

    blrfd_state_t st_q;
    blrfd_state_t st_d;

    logic [1:0]   wr_blk;
    logic [1:0]   rd_blk;
    logic [1:0]   irq_blk;

    // Word-aligned register select, shared by read and write paths
    function automatic logic blrfd_hit(
        input logic [`BLRFD_ADDR_W-1:0] a,
        input logic [`BLRFD_ADDR_W-1:0] off
    );
        return a[`BLRFD_ADDR_W-1:2] == off[`BLRFD_ADDR_W-1:2];
    endfunction : blrfd_hit

    // One decoder per section: 0 is application, 1 is boot
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sect
            localparam logic [2:0] HI =
                (g == 0) ? `BLRFD_APP_HI : `BLRFD_BOOT_HI;
            localparam logic [2:0] LO =
                (g == 0) ? `BLRFD_APP_LO : `BLRFD_BOOT_LO;
            localparam logic       IS_BOOT = (g == 1);
            logic sel;

            assign sel = acc_valid & (acc_boot == IS_BOOT);

            blrfd_sect u_sect (
                .prot_hi    (st_q.lock_q[HI]),
                .prot_lo    (st_q.lock_q[LO]),
                .acc_wr     (sel & acc_write),
                .acc_rd     (sel & ~acc_write),
                .from_other (exec_in_boot != IS_BOOT),
                .exec_here  (exec_in_boot == IS_BOOT),
                .ivec_other (ivec_in_boot != IS_BOOT),
                .wr_blk     (wr_blk[g]),
                .rd_blk     (rd_blk[g]),
                .irq_blk    (irq_blk[g])
            );
        end
    endgenerate

    // Next state of the whole block
    always_comb begin
        logic        req;
        logic        wr_fire;
        logic        blocked;
        logic        lvl_a;
        logic        lvl_b;
        logic [31:0] rmux;
        req     = avs_read | avs_write;
        wr_fire = avs_write & (st_q.bus_q == BLRFD_BUS_ACK);
        blocked = |(wr_blk | rd_blk);
        lvl_a   = 1'b0;
        lvl_b   = 1'b0;
        rmux    = 32'h0000_0000;
        st_d    = st_q;

        // Synchronisers run through reset so the snapshot is valid
        st_d.ext_s1_q  = ext_fuse_in;
        st_d.ext_s2_q  = st_q.ext_s1_q;
        st_d.lock_s1_q = lock_byte_in;
        st_d.lock_s2_q = st_q.lock_s1_q;

        if (!rst_n) begin
            // Snapshot is taken only while reset is low
            st_d.ext_q      = st_q.ext_s2_q;
            st_d.lock_q     = st_q.lock_s2_q;
            st_d.force_q    = ~st_q.ext_s2_q[`BLRFD_EXT_RB];
            lvl_a           = ~st_q.ext_s2_q[`BLRFD_EXT_RVA];
            lvl_b           = ~st_q.ext_s2_q[`BLRFD_EXT_RVB];
            // Not forcing: pins stay low as the port is idle in reset
            st_d.out_a_q    = st_d.force_q ? {3{lvl_a}} : 3'h0;
            st_d.out_b_q    = st_d.force_q ? {3{lvl_b}} : 3'h0;
            st_d.ocfg_q     = '0;
            st_d.bus_q      = BLRFD_BUS_IDLE;
            st_d.wait_q     = 1'b1;
            st_d.rdata_q    = 32'h0000_0000;
            st_d.grant_q    = 1'b0;
            st_d.deny_q     = 1'b0;
            st_d.irq_sup_q  = 1'b0;
            st_d.deny_stk_q = 1'b0;
            st_d.nv_wr_q    = 1'b0;
            st_d.nv_data_q  = st_q.lock_s2_q;
        end else begin
            // Access verdict, one cycle after the request
            st_d.grant_q   = acc_valid & ~blocked;
            st_d.deny_q    = acc_valid & blocked;
            st_d.irq_sup_q = |irq_blk;

            // Bus handshake: one wait cycle, then a one-cycle ack
            if (req && st_q.bus_q == BLRFD_BUS_IDLE) begin
                st_d.bus_q  = BLRFD_BUS_ACK;
                st_d.wait_q = 1'b0;
            end else begin
                st_d.bus_q  = BLRFD_BUS_IDLE;
                st_d.wait_q = 1'b1;
            end

            // Read data is staged during the wait cycle
            if (blrfd_hit(avs_address, `BLRFD_OFF_EXT)) begin
                rmux = {24'h0, st_q.ext_q};
            end else if (blrfd_hit(avs_address, `BLRFD_OFF_LOCK)) begin
                rmux = {24'h0, st_q.lock_q};
            end else if (blrfd_hit(avs_address, `BLRFD_OFF_OCFG)) begin
                rmux = {26'h0, st_q.ocfg_q};
            end else if (blrfd_hit(avs_address, `BLRFD_OFF_STAT)) begin
                rmux = {30'h0, st_q.deny_stk_q, st_q.force_q};
            end else if (blrfd_hit(avs_address, `BLRFD_OFF_LPROG)) begin
                rmux = {24'h0, st_q.nv_data_q};
            end else begin
                rmux = 32'h0000_0000;
            end
            if (avs_read && st_q.bus_q == BLRFD_BUS_IDLE) begin
                st_d.rdata_q = rmux;
            end

            // Any write to output configuration ends the forcing
            if (wr_fire && blrfd_hit(avs_address, `BLRFD_OFF_OCFG)) begin
                st_d.force_q = 1'b0;
                if (avs_byteenable[0]) begin
                    st_d.ocfg_q = avs_writedata[`BLRFD_OCFG_W-1:0];
                end
            end

            // Sticky deny flag: write one clears, a new deny wins
            if (wr_fire && blrfd_hit(avs_address, `BLRFD_OFF_STAT) &&
                avs_byteenable[0] && avs_writedata[`BLRFD_STAT_DENY]) begin
                st_d.deny_stk_q = 1'b0;
            end
            if (acc_valid && blocked) begin
                st_d.deny_stk_q = 1'b1;
            end

            // Lock image: writes only program bits, erase restores ones
            st_d.nv_wr_q = 1'b0;
            if (wr_fire && blrfd_hit(avs_address, `BLRFD_OFF_LPROG)) begin
                st_d.nv_wr_q = 1'b1;
                if (avs_writedata[`BLRFD_ERASE_BIT]) begin
                    st_d.nv_data_q = `BLRFD_UNPROG;
                end else if (avs_byteenable[0]) begin
                    st_d.nv_data_q = st_q.nv_data_q &
                                     avs_writedata[7:0];
                end
            end

            // Output drive follows the stage logic once released
            lvl_a = ~st_q.ext_q[`BLRFD_EXT_RVA];
            lvl_b = ~st_q.ext_q[`BLRFD_EXT_RVB];
            if (st_d.force_q) begin
                st_d.out_a_q = {3{lvl_a}};
                st_d.out_b_q = {3{lvl_b}};
            end else begin
                st_d.out_a_q = stage_a_in;
                st_d.out_b_q = stage_b_in;
            end
        end
    end

    // Single state register
    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    // Every output straight from the state register
    assign avs_readdata    = st_q.rdata_q;
    assign avs_waitrequest = st_q.wait_q;
    assign lock_nv_wr      = st_q.nv_wr_q;
    assign lock_nv_data    = st_q.nv_data_q;
    assign acc_grant       = st_q.grant_q;
    assign acc_deny        = st_q.deny_q;
    assign irq_suppress    = st_q.irq_sup_q;
    assign stage_output_a  = st_q.out_a_q;
    assign stage_output_b  = st_q.out_b_q;
    assign stage_force     = st_q.force_q;

    // Checks, all on clk and quiet during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_app_open;
        acc_valid && !acc_boot &&
        st_q.lock_q[`BLRFD_APP_HI] && st_q.lock_q[`BLRFD_APP_LO]
        |=> acc_grant && !acc_deny;
    endproperty
    a_app_open: assert property (p_app_open)
        else $error("open application access was not granted");

    property p_app_wr;
        acc_valid && acc_write && !acc_boot &&
        !st_q.lock_q[`BLRFD_APP_LO]
        |=> acc_deny && !acc_grant;
    endproperty
    a_app_wr: assert property (p_app_wr)
        else $error("application self-write was not blocked");

    property p_app_rd;
        acc_valid && !acc_write && !acc_boot && exec_in_boot &&
        !st_q.lock_q[`BLRFD_APP_HI]
        |=> acc_deny;
    endproperty
    a_app_rd: assert property (p_app_rd)
        else $error("boot read of application was not blocked");

    property p_app_m4;
        acc_valid && acc_write && !acc_boot &&
        !st_q.lock_q[`BLRFD_APP_HI] && st_q.lock_q[`BLRFD_APP_LO]
        |=> acc_grant;
    endproperty
    a_app_m4: assert property (p_app_m4)
        else $error("application write wrongly blocked");

    property p_app_irq;
        !exec_in_boot && ivec_in_boot && !st_q.lock_q[`BLRFD_APP_HI]
        |=> irq_suppress;
    endproperty
    a_app_irq: assert property (p_app_irq)
        else $error("interrupts not masked in application");

    property p_boot_open;
        acc_valid && acc_boot &&
        st_q.lock_q[`BLRFD_BOOT_HI] && st_q.lock_q[`BLRFD_BOOT_LO]
        |=> acc_grant && !acc_deny;
    endproperty
    a_boot_open: assert property (p_boot_open)
        else $error("open boot access was not granted");

    property p_boot_wr;
        acc_valid && acc_write && acc_boot &&
        !st_q.lock_q[`BLRFD_BOOT_LO]
        |=> acc_deny;
    endproperty
    a_boot_wr: assert property (p_boot_wr)
        else $error("boot self-write was not blocked");

    property p_boot_rd;
        acc_valid && !acc_write && acc_boot && !exec_in_boot &&
        !st_q.lock_q[`BLRFD_BOOT_HI]
        |=> acc_deny;
    endproperty
    a_boot_rd: assert property (p_boot_rd)
        else $error("application read of boot was not blocked");

    property p_boot_irq;
        exec_in_boot && !ivec_in_boot && !st_q.lock_q[`BLRFD_BOOT_HI]
        |=> irq_suppress;
    endproperty
    a_boot_irq: assert property (p_boot_irq)
        else $error("interrupts not masked in boot");

    property p_release;
        $fell(stage_force) |-> $past(avs_write) &&
            $past(blrfd_hit(avs_address, `BLRFD_OFF_OCFG));
    endproperty
    a_release: assert property (p_release)
        else $error("forcing ended without a config write");

    property p_lvl;
        stage_force |-> stage_output_a ==
            {3{~st_q.ext_q[`BLRFD_EXT_RVA]}} &&
            stage_output_b == {3{~st_q.ext_q[`BLRFD_EXT_RVB]}};
    endproperty
    a_lvl: assert property (p_lvl)
        else $error("forced output level is wrong");

    property p_frozen;
        ##1 $stable(st_q.ext_q) && $stable(st_q.lock_q);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("fuse snapshot changed while running");

    property p_onlyprog;
        lock_nv_wr |-> lock_nv_data == `BLRFD_UNPROG ||
            (lock_nv_data & ~$past(lock_nv_data)) == 8'h00;
    endproperty
    a_onlyprog: assert property (p_onlyprog)
        else $error("lock bit returned to one without erase");

    property p_ack;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack)
        else $error("waitrequest low for more than one cycle");
endmodule : blrfd_top

`default_nettype wire
